// *** energy_pkg.sv ***
// Purpose: shared constants for the energy pause controller
// Assumes: 32-bit AHB-Lite register window, low 12 address bits decoded
// Notes: offsets are byte addresses, one aligned word per register
`default_nettype none
package energy_pkg;
  // default sizes
  localparam int N_SUB_DEF = 4;
  localparam int CH_PER_SUB_DEF = 2;
  localparam int CH_W_DEF = 16;
  localparam int TIME_W_DEF = 16;
  localparam int DATA_W = 32;
  // address decode
  localparam int REG_AW = 12;
  localparam int REGION_LSB = 8;
  localparam int WORD_LSB = 2;
  localparam int IDX_W = REGION_LSB - WORD_LSB;
  localparam logic [REG_AW-1:0] CTRL_OFS = 12'h000;
  localparam logic [REG_AW-1:0] CMD_OFS = 12'h004;
  localparam logic [REG_AW-1:0] PAUSE_REQ_OFS = 12'h008;
  localparam logic [REG_AW-1:0] RESULT_OFS = 12'h00c;
  localparam logic [REG_AW-1:0] AP_MIN_OFS = 12'h010;
  localparam logic [REG_AW-1:0] PAUSED_OFS = 12'h014;
  localparam logic [REG_AW-1:0] MIN_BASE = 12'h100;
  localparam logic [REG_AW-1:0] SUBST_BASE = 12'h200;
  // control fields
  localparam int CTRL_VARIANT_BIT = 0;
  localparam int CTRL_OWNER_BIT = 1;
  // command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_OP_W = 3;
  localparam int FIELD_W = 4;
  localparam int CMD_SLOT_LSB = 8;
  localparam int CMD_SUB_LSB = 12;
  localparam int CMD_CONN_BIT = 16;
  localparam int CMD_W = 17;
  localparam logic [3:0] AP_SLOT = 4'h0;
  localparam logic [3:0] FIRST_SUBMOD = 4'h1;
  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_ENTER = 3'h1,
    CMD_LEAVE = 3'h2,
    CMD_LIST_MODES = 3'h3,
    CMD_QUERY_MODE = 3'h4,
    CMD_QUERY_MEAS = 3'h5,
    CMD_LIST_CMDS = 3'h6
  } cmd_op_e;
  // result word fields
  localparam int RES_W = 16;
  localparam int RES_DONE_BIT = 0;
  localparam int RES_REJECT_BIT = 1;
  localparam int RES_APPLIED_BIT = 2;
  localparam int RES_DATA_LSB = 8;
  localparam int RES_DATA_W = 8;
  // status answers, values arbitrary
  localparam logic [7:0] MODE_READY_ID = 8'h00;
  localparam logic [7:0] MODE_PAUSE_ID = 8'h01;
  localparam logic [7:0] MEAS_NONE = 8'h00;
  localparam logic [7:0] SUPPORTED_CMDS = 8'h7e;
  // bus encodings
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;
endpackage : energy_pkg
`default_nettype wire

// *** pause_if.sv ***
// Purpose: pause command path between decoder, pause state and output stage
// Assumes: all users on core_clk
// Notes: enter and leave are one-cycle strobes
`timescale 1ns/1ps
`default_nettype none
interface pause_if #(parameter int N_SUB = 4, parameter int TW = 16);
  logic enter;
  logic leave;
  logic ap_mode;
  logic [N_SUB-1:0] target;
  logic [TW-1:0] req_time;
  logic [TW-1:0] ap_min;
  logic [N_SUB-1:0][TW-1:0] mins;
  logic [N_SUB-1:0] qual;
  logic [N_SUB-1:0] paused;
  modport ctrl (output enter, leave, ap_mode, target, req_time, ap_min, mins,
                input qual, paused);
  modport core (input enter, leave, ap_mode, target, req_time, ap_min, mins,
                output qual, paused);
  modport view (input paused);
endinterface : pause_if
`default_nettype wire

// *** pause_core.sv ***
// Purpose: per-submodule pause state with minimum-time qualification
// Assumes: enter and leave never in the same cycle
// Notes: pause ends only through a leave strobe
`timescale 1ns/1ps
`default_nettype none
module pause_core
  import energy_pkg::*;
#(
  parameter int N_SUB = N_SUB_DEF,
  parameter int TW = TIME_W_DEF
)
(
  input wire logic core_clk,
  input wire logic arst_n,
  pause_if.core pif
);
  typedef struct packed {
    logic [N_SUB-1:0] paused;
  } core_s;
  core_s r;
  core_s next_r;
  genvar i;

  // station-wide requests compare against the access point minimum only
  generate
    for (i = 0; i < N_SUB; i++)
    begin : g_sub
      assign pif.qual[i] = pif.req_time >= (pif.ap_mode ? pif.ap_min : pif.mins[i]);
      AST_ENTER_APPLIES: assert property (@(posedge core_clk) disable iff (!arst_n)
        pif.enter && pif.target[i] && pif.qual[i] |=> pif.paused[i])
        else $error("qualifying enter did not pause the submodule");
      AST_BELOW_MIN_HOLD: assert property (@(posedge core_clk) disable iff (!arst_n)
        pif.enter && pif.target[i] && !pif.qual[i] |=> pif.paused[i] == $past(pif.paused[i]))
        else $error("short pause request changed the pause state");
      AST_NO_SELF_EXIT: assert property (@(posedge core_clk) disable iff (!arst_n)
        pif.paused[i] && !(pif.leave && pif.target[i]) |=> pif.paused[i])
        else $error("submodule left pause without a leave command");
    end
  endgenerate

  // next pause state
  always_comb
  begin
    next_r = r;
    for (int k = 0; k < N_SUB; k++)
    begin
      if (pif.enter && pif.target[k] && pif.qual[k])
        next_r.paused[k] = 1'b1;
      else if (pif.leave && pif.target[k])
        next_r.paused[k] = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      r <= '0;
    else
      r <= next_r;
  end

  assign pif.paused = r.paused;

  AST_STATION_WIDE: assert property (@(posedge core_clk) disable iff (!arst_n)
    pif.enter && pif.ap_mode && (&pif.target) && pif.qual[0] |=> (&pif.paused))
    else $error("station-wide pause missed a submodule");
endmodule : pause_core
`default_nettype wire

// *** output_mux.sv ***
// Purpose: registered choice between application and substitute values
// Assumes: app values come from logic on core_clk
// Notes: one cycle from pause state to the channel outputs
`timescale 1ns/1ps
`default_nettype none
module output_mux
  import energy_pkg::*;
#(
  parameter int N_SUB = N_SUB_DEF,
  parameter int CPS = CH_PER_SUB_DEF,
  parameter int CW = CH_W_DEF,
  parameter int N_CH = N_SUB * CPS
)
(
  input wire logic core_clk,
  input wire logic arst_n,
  pause_if.view pif,
  input wire logic [N_CH-1:0][CW-1:0] app,
  input wire logic [N_CH-1:0][CW-1:0] subst,
  output logic [N_CH-1:0][CW-1:0] chan_out
);
  typedef struct packed {
    logic [N_CH-1:0][CW-1:0] out;
  } mux_s;
  mux_s r;
  mux_s next_r;
  genvar c;

  // each channel follows the pause state of its own submodule
  always_comb
  begin
    next_r = r;
    for (int k = 0; k < N_CH; k++)
      next_r.out[k] = pif.paused[k / CPS] ? subst[k] : app[k];
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      r <= '0;
    else
      r <= next_r;
  end

  assign chan_out = r.out;

  generate
    for (c = 0; c < N_CH; c++)
    begin : g_chk
      AST_SUBST_OUT: assert property (@(posedge core_clk) disable iff (!arst_n)
        pif.paused[c / CPS] |=> chan_out[c] == $past(subst[c]))
        else $error("paused channel does not show its substitute value");
    end
  endgenerate
endmodule : output_mux
`default_nettype wire

// *** energy_pause_controller.sv ***
// Purpose: energy pause command interpreter with AHB-Lite register access
// Assumes: single-word AHB-Lite transfers, app outputs on core_clk
// Notes: commands execute in the write data phase of the command register
//
// Summary of operation
// - Two control and four status commands are taken, any other code is refused.
// - Every energy submodule keeps its own writable minimum pause time.
// - An enter request at or above the applicable minimum switches outputs to substitutes.
// - A paused submodule stays paused until a leave command addresses it.
// - One substitute value per channel is stored, held inside the output range.
// - Status commands answer with the addressed submodule's state or supported commands.
// - Commands decode either to a submodule slot or to access point submodule one.
// - In the standard variant the access point submodule refuses energy commands.
// - In the energy variant the owner reaches only the access point, where only its minimum counts.
// - A qualifying station-wide enter pauses every energy submodule at once.
// - Only the owning connection reaches the access point, others work per submodule.
`timescale 1ns/1ps
`default_nettype none
module energy_pause_controller
  import energy_pkg::*;
#(
  parameter int N_SUB = N_SUB_DEF,
  parameter int CPS = CH_PER_SUB_DEF,
  parameter int CW = CH_W_DEF,
  parameter int TW = TIME_W_DEF,
  parameter int N_CH = N_SUB * CPS,
  parameter logic [CW-1:0] OUT_MIN = '0,
  parameter logic [CW-1:0] OUT_MAX = '1
)
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [DATA_W-1:0] hrdata,
  output logic hresp,
  input wire logic [N_CH-1:0][CW-1:0] app_out,
  output logic [N_CH-1:0][CW-1:0] chan_out,
  output logic [N_SUB-1:0] paused
);
  typedef struct packed {
    logic dph;
    logic dwr;
    logic [REG_AW-1:0] dadr;
    logic [DATA_W-1:0] rdata;
    logic ap_variant;
    logic owner;
    logic [CMD_W-1:0] cmd;
    logic [TW-1:0] req_time;
    logic [TW-1:0] ap_min;
    logic [N_SUB-1:0][TW-1:0] mins;
    logic [N_CH-1:0][CW-1:0] subst;
    logic [RES_W-1:0] result;
  } regs_s;

  regs_s r;
  regs_s next_r;

  // address phase and write decode
  logic ap_take;
  logic [IDX_W-1:0] widx;
  logic min_wr;
  logic subst_wr;
  logic [TW-1:0] wr_time;

  // command decode
  cmd_op_e op;
  logic [FIELD_W-1:0] slot;
  logic [FIELD_W-1:0] subn;
  logic conn;
  logic cmd_fire;
  logic at_ap;
  logic at_sub;
  logic op_known;
  logic rej_std;
  logic rej_energy;
  logic rej_foreign;
  logic reject;
  logic accept;
  logic sel_paused;
  logic [N_SUB-1:0] target;
  logic [RES_DATA_W-1:0] status_data;
  genvar i;

  pause_if #(.N_SUB(N_SUB), .TW(TW)) pif ();

  pause_core #(
    .N_SUB(N_SUB),
    .TW(TW)
  ) u_core (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .pif(pif)
  );

  output_mux #(
    .N_SUB(N_SUB),
    .CPS(CPS),
    .CW(CW),
    .N_CH(N_CH)
  ) u_mux (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .pif(pif),
    .app(app_out),
    .subst(r.subst),
    .chan_out(chan_out)
  );

  // zero-wait slave, every transfer answered okay
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign hrdata = r.rdata;
  assign paused = pif.paused;

  // only whole-word active transfers are taken, others are ignored
  assign ap_take = hsel && htrans[HTRANS_ACTIVE_BIT] && hready && (hsize == HSIZE_WORD);
  assign widx = r.dadr[REGION_LSB-1:WORD_LSB];
  assign wr_time = hwdata[TW-1:0];
  assign min_wr = r.dph && r.dwr && (r.dadr[REG_AW-1:REGION_LSB] == MIN_BASE[REG_AW-1:REGION_LSB])
    && (widx < IDX_W'(N_SUB));
  assign subst_wr = r.dph && r.dwr
    && (r.dadr[REG_AW-1:REGION_LSB] == SUBST_BASE[REG_AW-1:REGION_LSB])
    && (widx < IDX_W'(N_CH));

  // command word fields, taken straight from the write data phase
  assign op = cmd_op_e'(hwdata[CMD_OP_LSB +: CMD_OP_W]);
  assign slot = hwdata[CMD_SLOT_LSB +: FIELD_W];
  assign subn = hwdata[CMD_SUB_LSB +: FIELD_W];
  assign conn = hwdata[CMD_CONN_BIT];
  assign cmd_fire = r.dph && r.dwr && (r.dadr == CMD_OFS);

  // two addressing forms: a submodule slot or access point submodule one
  assign at_ap = (slot == AP_SLOT) && (subn == FIRST_SUBMOD);
  assign at_sub = (slot != AP_SLOT) && (slot <= FIELD_W'(N_SUB)) && (subn == FIRST_SUBMOD);

  assign op_known = (op == CMD_ENTER) || (op == CMD_LEAVE) || (op == CMD_LIST_MODES)
    || (op == CMD_QUERY_MODE) || (op == CMD_QUERY_MEAS) || (op == CMD_LIST_CMDS);

  // refusal causes, checked against the configured variant and owner
  assign rej_std = at_ap && !r.ap_variant;
  assign rej_energy = at_sub && r.ap_variant && (conn == r.owner);
  assign rej_foreign = at_ap && (conn != r.owner);
  assign reject = !op_known || !(at_ap || at_sub) || rej_std || rej_energy || rej_foreign;
  assign accept = cmd_fire && !reject;

  generate
    for (i = 0; i < N_SUB; i++)
    begin : g_target
      assign target[i] = at_ap || (at_sub && (slot == FIELD_W'(i + 1)));
    end
  endgenerate

  // strobes toward the pause state
  assign pif.enter = accept && (op == CMD_ENTER);
  assign pif.leave = accept && (op == CMD_LEAVE);
  assign pif.ap_mode = at_ap;
  assign pif.target = target;
  assign pif.req_time = r.req_time;
  assign pif.ap_min = r.ap_min;
  assign pif.mins = r.mins;

  // station-wide query reports pause only once every submodule is paused
  assign sel_paused = at_ap ? (&pif.paused) : (|(target & pif.paused));

  // answer payload for status commands
  always_comb
  begin
    status_data = '0;
    unique case (op)
      CMD_LIST_MODES: status_data = MODE_PAUSE_ID;
      CMD_QUERY_MODE: status_data = sel_paused ? MODE_PAUSE_ID : MODE_READY_ID;
      CMD_QUERY_MEAS: status_data = MEAS_NONE;
      CMD_LIST_CMDS: status_data = SUPPORTED_CMDS;
      default: status_data = '0;
    endcase
  end

  // keeps every substitute inside the output range, whatever software writes
  function automatic logic [CW-1:0] clamp(input logic [CW-1:0] v);
    if (v < OUT_MIN)
      return OUT_MIN;
    if (v > OUT_MAX)
      return OUT_MAX;
    return v;
  endfunction : clamp

  // register read mux, unmapped addresses read as zero
  function automatic logic [DATA_W-1:0] read_word(input logic [REG_AW-1:0] a);
    logic [DATA_W-1:0] w;
    logic [IDX_W-1:0] idx;
    w = '0;
    idx = a[REGION_LSB-1:WORD_LSB];
    if (a == CTRL_OFS)
    begin
      w[CTRL_VARIANT_BIT] = r.ap_variant;
      w[CTRL_OWNER_BIT] = r.owner;
    end
    else if (a == CMD_OFS)
      w[CMD_W-1:0] = r.cmd;
    else if (a == PAUSE_REQ_OFS)
      w[TW-1:0] = r.req_time;
    else if (a == RESULT_OFS)
      w[RES_W-1:0] = r.result;
    else if (a == AP_MIN_OFS)
      w[TW-1:0] = r.ap_min;
    else if (a == PAUSED_OFS)
      w[N_SUB-1:0] = pif.paused;
    else if ((a[REG_AW-1:REGION_LSB] == MIN_BASE[REG_AW-1:REGION_LSB]) && (idx < IDX_W'(N_SUB)))
      w[TW-1:0] = r.mins[idx];
    else if ((a[REG_AW-1:REGION_LSB] == SUBST_BASE[REG_AW-1:REGION_LSB])
      && (idx < IDX_W'(N_CH)))
      w[CW-1:0] = r.subst[idx];
    return w;
  endfunction : read_word

  // next state: bus pipeline, register writes and command result
  always_comb
  begin
    next_r = r;
    next_r.dph = ap_take;
    next_r.dwr = hwrite;
    next_r.dadr = haddr[REG_AW-1:0];
    // read data is fetched in the address phase so the data phase needs no wait
    if (ap_take && !hwrite)
      next_r.rdata = read_word(haddr[REG_AW-1:0]);
    if (r.dph && r.dwr)
    begin
      if (r.dadr == CTRL_OFS)
      begin
        next_r.ap_variant = hwdata[CTRL_VARIANT_BIT];
        next_r.owner = hwdata[CTRL_OWNER_BIT];
      end
      else if (r.dadr == PAUSE_REQ_OFS)
        next_r.req_time = wr_time;
      else if (r.dadr == AP_MIN_OFS)
        next_r.ap_min = wr_time;
      else if (r.dadr == CMD_OFS)
        next_r.cmd = hwdata[CMD_W-1:0];
      else if (min_wr)
        next_r.mins[widx] = wr_time;
      else if (subst_wr)
        next_r.subst[widx] = clamp(hwdata[CW-1:0]);
    end
    // every command overwrites the result word, so no flag is cleared by software
    if (cmd_fire)
    begin
      next_r.result = '0;
      next_r.result[RES_DONE_BIT] = 1'b1;
      next_r.result[RES_REJECT_BIT] = reject;
      next_r.result[RES_APPLIED_BIT] = pif.enter && (|(target & pif.qual));
      if (!reject)
        next_r.result[RES_DATA_LSB +: RES_DATA_W] = status_data;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      r <= '0;
      for (int k = 0; k < N_CH; k++)
        r.subst[k] <= OUT_MIN; // reset value stays within range
    end
    else
      r <= next_r;
  end

  AST_UNKNOWN_OP: assert property (@(posedge core_clk) disable iff (!arst_n)
    cmd_fire && !op_known |=> r.result[RES_REJECT_BIT] && !pif.enter && !pif.leave)
    else $error("unknown command code was not refused");

  AST_AP_STD_REJECT: assert property (@(posedge core_clk) disable iff (!arst_n)
    cmd_fire && at_ap && !r.ap_variant |-> !pif.enter ##1 r.result[RES_REJECT_BIT])
    else $error("access point took a command in the standard variant");

  AST_SUB_ENERGY_REJECT: assert property (@(posedge core_clk) disable iff (!arst_n)
    cmd_fire && at_sub && r.ap_variant && (conn == r.owner) |=> r.result[RES_REJECT_BIT])
    else $error("owner reached a submodule in the energy variant");

  AST_FOREIGN_AP_REJECT: assert property (@(posedge core_clk) disable iff (!arst_n)
    cmd_fire && at_ap && (conn != r.owner) |-> !pif.enter && !pif.leave ##1 r.result[RES_REJECT_BIT])
    else $error("second connection reached the access point");

  AST_QUERY_MODE: assert property (@(posedge core_clk) disable iff (!arst_n)
    accept && (op == CMD_QUERY_MODE) && at_sub && (|(target & pif.paused))
    |=> r.result[RES_DATA_LSB +: RES_DATA_W] == MODE_PAUSE_ID)
    else $error("mode query did not report the pause state");

  AST_MIN_WRITE: assert property (@(posedge core_clk) disable iff (!arst_n)
    min_wr |=> r.mins[$past(widx)] == $past(wr_time))
    else $error("minimum pause time was not stored");

  AST_DECODE: assert property (@(posedge core_clk) disable iff (!arst_n)
    cmd_fire |-> (at_sub -> $onehot(target)) && (at_ap -> (&target)))
    else $error("command address decoded to the wrong submodules");

  AST_PAUSE_TO_PIN: assert property (@(posedge core_clk) disable iff (!arst_n)
    pif.enter && pif.target[0] && pif.qual[0] |-> ##2 chan_out[0] == r.subst[0])
    else $error("substitute value missing two cycles after a qualifying enter");

  // a leave clears every submodule it addressed, with no time check
  AST_LEAVE_CLEARS: assert property (@(posedge core_clk) disable iff (!arst_n)
    pif.leave |=> (pif.paused & $past(pif.target)) == '0)
    else $error("leave command did not end the pause");

  // a refused command must leave every pause bit where it was
  AST_REJECT_NO_CHANGE: assert property (@(posedge core_clk) disable iff (!arst_n)
    cmd_fire && reject |=> pif.paused == $past(pif.paused))
    else $error("refused command changed the pause state");

  // a short request is accepted but reports nothing applied
  AST_SHORT_NOT_APPLIED: assert property (@(posedge core_clk) disable iff (!arst_n)
    pif.enter && !(|(target & pif.qual))
    |=> !r.result[RES_APPLIED_BIT] && (pif.paused == $past(pif.paused)))
    else $error("short pause request was reported as applied");

  // station-wide requests ignore the per-submodule minimums
  AST_AP_MIN_ONLY: assert property (@(posedge core_clk) disable iff (!arst_n)
    pif.enter && pif.ap_mode |-> pif.qual == {N_SUB{pif.req_time >= pif.ap_min}})
    else $error("station-wide request used a submodule minimum");

  // the second connection keeps its per-submodule path
  AST_FOREIGN_SUB_OK: assert property (@(posedge core_clk) disable iff (!arst_n)
    cmd_fire && op_known && at_sub && (conn != r.owner) |=> !r.result[RES_REJECT_BIT])
    else $error("second connection was refused at a submodule");

  // status commands only report, they never move the pause state
  AST_STATUS_NO_CHANGE: assert property (@(posedge core_clk) disable iff (!arst_n)
    cmd_fire && (op inside {CMD_LIST_MODES, CMD_QUERY_MODE, CMD_QUERY_MEAS, CMD_LIST_CMDS})
    |=> pif.paused == $past(pif.paused))
    else $error("status command changed the pause state");

  // every stored substitute stays inside the output range
  generate
    for (i = 0; i < N_CH; i++)
    begin : g_range
      AST_SUBST_RANGE: assert property (@(posedge core_clk) disable iff (!arst_n)
        (r.subst[i] >= OUT_MIN) && (r.subst[i] <= OUT_MAX))
        else $error("substitute value left the output range");
    end
  endgenerate
endmodule : energy_pause_controller
`default_nettype wire

// *** net_controller.sv ***
// Purpose: behavioural network controller that issues energy commands over the register bus
// Assumes: one slave whose hreadyout is the bus hready
// Notes: single word transfers only, address and data phases never overlap
`timescale 1ns/1ps
`default_nettype none
module net_controller
  import energy_pkg::*;
(
  input wire logic core_clk,
  input wire logic hready,
  input wire logic [DATA_W-1:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [DATA_W-1:0] hwdata
);
  // idle bus before the first transfer
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0;
  end

  // each phase is held until hready is seen high, no wait count is assumed
  task automatic xfer(input logic wr, input logic [REG_AW-1:0] ofs,
                      input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {20'h0, ofs};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    @(posedge core_clk);
    while (hready !== 1'b1)
      @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    // address already taken, so a stale address cannot be reused
    haddr <= ~haddr;
    if (wr)
      hwdata <= wd;
    @(posedge core_clk);
    while (hready !== 1'b1)
      @(posedge core_clk);
    rd = hrdata;
    // released data lines show the inverse so a stale value cannot pass
    hwdata <= ~hwdata;
  endtask : xfer
endmodule : net_controller
`default_nettype wire

// *** tb_energy_pause_controller.sv ***
// Purpose: self-checking bench for the energy pause controller
// Assumes: no wait states, one slave on the bus
// Notes: substitute range narrowed by parameters so that clamping shows
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e, m) begin checked++; if ((a) !== (e)) begin err_total++; \
  $display("ERROR t=%0t %s got %h exp %h", $time, m, a, e); end end
module tb_energy_pause_controller;
  import energy_pkg::*;
  localparam int NC = 8;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic [NC-1:0][15:0] app_out;
  logic [NC-1:0][15:0] chan_out;
  logic [3:0] paused;
  logic [31:0] rdat;
  logic [7:0] st [3:6] = '{8'h01, MODE_PAUSE_ID, MEAS_NONE, SUPPORTED_CMDS};
  int err_total = 0;
  int checked = 0;

  always #5 core_clk = ~core_clk;

  energy_pause_controller #(.OUT_MIN(16'h0010), .OUT_MAX(16'h0fff)) energy_pause_controller_inst (
    .core_clk(core_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .app_out(app_out),
    .chan_out(chan_out), .paused(paused));

  net_controller net_controller_inst (
    .core_clk(core_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    net_controller_inst.xfer(1'b1, a, d, rdat);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    net_controller_inst.xfer(1'b0, a, 32'h0, rdat);
    `CHK(rdat, e, "read data")
    `CHK(hresp, HRESP_OKAY, "response")
  endtask : rd

  // access point is slot 0 submodule 1, energy submodules are slots 1 and up
  function automatic logic [31:0] cw(input int op, input int slot, input int sub, input int cn);
    return (32'(cn) << CMD_CONN_BIT) | (32'(sub) << CMD_SUB_LSB) |
      (32'(slot) << CMD_SLOT_LSB) | 32'(op);
  endfunction : cw

  task automatic cmd(input int op, input int slot, input int sub, input int cn,
                     input logic [15:0] e);
    wr(CMD_OFS, cw(op, slot, sub, cn));
    rd(RESULT_OFS, {16'h0, e});
  endtask : cmd

  // a paused submodule shows its two substitutes, all others the app values
  task automatic chk_out(input logic [3:0] m);
    for (int c = 0; c < NC; c++)
      `CHK(chan_out[c], m[c / 2] ? 16'h0a00 + 16'(c) : 16'h1000 + 16'(c), "channel")
    `CHK(paused, m, "paused pins")
    rd(PAUSED_OFS, {28'h0, m});
  endtask : chk_out

  // hang guard, the tests need a few hundred cycles
  initial
  begin
    #200000;
    err_total++;
    tally_and_finish;
  end

  initial
  begin
    for (int c = 0; c < NC; c++)
      app_out[c] <= 16'h1000 + 16'(c);
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    rd(CTRL_OFS, 32'h0);
    rd(PAUSED_OFS, 32'h0);
    rd(SUBST_BASE, 32'h0010);
    wr(12'h300, 32'hffff_ffff);
    rd(12'h300, 32'h0);
    $display("test reset done");
    wr(SUBST_BASE, 32'hffff);
    rd(SUBST_BASE, 32'h0fff);
    wr(SUBST_BASE + 12'h4, 32'h0);
    rd(SUBST_BASE + 12'h4, 32'h0010);
    for (int c = 0; c < NC; c++)
    begin
      wr(SUBST_BASE + 12'(4 * c), 32'h0a00 + 32'(c));
      rd(SUBST_BASE + 12'(4 * c), 32'h0a00 + 32'(c));
    end
    // distinct minimums so submodules 1 and 2 each prove their own threshold
    for (int i = 0; i < 4; i++)
      wr(MIN_BASE + 12'(4 * i), 32'd100 + 32'(10 * i));
    rd(MIN_BASE + 12'h8, 32'd120);
    $display("test registers done");
    wr(PAUSE_REQ_OFS, 32'd99);
    cmd(CMD_ENTER, 1, 1, 0, 16'h0001);
    chk_out(4'h0);
    wr(PAUSE_REQ_OFS, 32'd100);
    cmd(CMD_ENTER, 2, 1, 0, 16'h0001);
    cmd(CMD_ENTER, 1, 1, 0, 16'h0005);
    chk_out(4'h1);
    repeat (50) @(posedge core_clk);
    cmd(CMD_LEAVE, 2, 1, 0, 16'h0001);
    chk_out(4'h1);
    for (int op = 3; op <= 6; op++)
      cmd(op, 1, 1, 0, {st[op], 8'h01});
    cmd(CMD_QUERY_MODE, 3, 1, 0, {MODE_READY_ID, 8'h01});
    cmd(CMD_LEAVE, 1, 1, 0, 16'h0001);
    chk_out(4'h0);
    $display("test standard pause done");
    wr(PAUSE_REQ_OFS, 32'd500);
    cmd(CMD_ENTER, 0, 1, 0, 16'h0003);
    cmd(CMD_ENTER, 5, 1, 0, 16'h0003);
    cmd(CMD_ENTER, 1, 2, 0, 16'h0003);
    cmd(0, 1, 1, 0, 16'h0003);
    cmd(7, 1, 1, 0, 16'h0003);
    chk_out(4'h0);
    $display("test refusals done");
    // energy variant, connection 0 owns the access point
    wr(CTRL_OFS, 32'h1);
    wr(AP_MIN_OFS, 32'd200);
    wr(PAUSE_REQ_OFS, 32'd150);
    cmd(CMD_ENTER, 0, 1, 0, 16'h0001);
    // owner mixing in a per-submodule command on purpose, must be refused
    cmd(CMD_ENTER, 1, 1, 0, 16'h0003);
    cmd(CMD_ENTER, 0, 1, 1, 16'h0003);
    cmd(CMD_ENTER, 2, 1, 1, 16'h0005);
    chk_out(4'h2);
    cmd(CMD_LEAVE, 2, 1, 1, 16'h0001);
    wr(PAUSE_REQ_OFS, 32'd200);
    cmd(CMD_ENTER, 0, 1, 0, 16'h0005);
    chk_out(4'hf);
    cmd(CMD_QUERY_MODE, 0, 1, 0, {MODE_PAUSE_ID, 8'h01});
    cmd(CMD_LEAVE, 0, 1, 0, 16'h0001);
    chk_out(4'h0);
    $display("test energy variant done");
    tally_and_finish;
  end
endmodule : tb_energy_pause_controller
`default_nettype wire
